// ### bench/eop_ctrl_tb.sv
// self-checking bench for the eprom programming and option control block
// assumes the pin source model and a classic wishbone master in tasks
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module eop_ctrl_tb;
   localparam int PROG = 8;
   localparam int PBASE = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [17:0] wb_adr_i = 18'h0_0000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, tvl, pbb, erase, boot, jump, pbb_rel, vec, ppow;
   logic slow, sec, osc, pdone, tick;
   logic [2:0] dsel;
   logic [1:0] req = 2'b00;
   logic [7:0] rd;
   int mismatches = 0;
   int checked = 0;
   int jumps = 0;
   int ticks = 0;
   // 20 MHz clock
   always #25 clk_i = ~clk_i;
   eop_pin_source i_pins (.clk_i(clk_i), .req_i(req), .test_voltage_level_o(tvl),
      .port_b_bit1_pin_o(pbb));
   eop_ctrl #(.PROG_CYCLES(PROG), .POR_BASE(PBASE)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .test_voltage_level_i(tvl), .port_b_bit1_pin_i(pbb), .array_erase_i(erase),
      .boot_mode_o(boot), .boot_jump_o(jump), .port_b_bit1_released_o(pbb_rel),
      .vectors_from_eprom_o(vec), .prog_power_o(ppow), .slow_mode_o(slow),
      .security_lock_o(sec), .osc_type_select_o(osc), .por_delay_sel_o(dsel),
      .por_done_o(pdone), .cpu_tick_o(tick));
   // pulse counters, counted mid-cycle so the main sequence never races them
   always @(negedge clk_i) begin
      if (jump === 1'b1) jumps++;
      if (tick === 1'b1) ticks++;
   end
   // closing: counts, verdict, end of run
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // one classic wishbone cycle, held until ack is sampled high
   task automatic wb_cycle(input logic we, input logic [17:0] adr, input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h00_0000, d};
      // only the watchdog ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb_cycle
   task automatic wr(input logic [17:0] adr, input logic [7:0] d);
      wb_cycle(1'b1, adr, d);
   endtask : wr
   task automatic rd_chk(input logic [17:0] adr, input logic [7:0] exp);
      wb_cycle(1'b0, adr, 8'h00);
      `CHK(rd, exp);
   endtask : rd_chk
   // pins set well ahead of the release edge, reset held past the synchronisers
   task automatic do_reset(input logic [1:0] pins);
      req <= pins;
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      jumps = 0;
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : do_reset
   // full burn of one location, finished by one control write
   task automatic burn(input logic [17:0] adr, input logic [7:0] d);
      wr(18'h0_0034, 8'h02);
      wr(adr, d);
      wr(18'h0_0034, 8'h03);
      @(posedge clk_i);
      `CHK(ppow, 1'b1);
      repeat (PROG + 2) @(posedge clk_i);
      wr(18'h0_0034, 8'h00);
      @(posedge clk_i);
      `CHK(ppow, 1'b0);
      rd_chk(18'h0_0034, 8'h00);
   endtask : burn
   // run needs about 400 cycles; watchdog fires at 2000
   initial begin
      #(2000 * 50);
      mismatches++;
      print_verdict();
   end
   // main sequence
   initial begin
      // erase the cells and hold reset two cycles with both mode pins low
      erase <= 1'b1;
      repeat (2) @(posedge clk_i);
      erase <= 1'b0;
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK(boot, 1'b0);
      `CHK(vec, 1'b1);
      `CHK({slow, sec, dsel, osc}, 6'h00);
      `CHK(pdone, 1'b0);
      repeat (6) @(posedge clk_i);
      `CHK(pdone, 1'b1);
      ticks = 0;
      repeat (64) @(posedge clk_i);
      `CHK(ticks, 64);
      rd_chk(18'h0_0034, 8'h00);
      rd_chk(18'h0_3ffc, 8'h00);
      rd_chk(18'h0_7c00, 8'h00);
      rd_chk(18'h0_0030, 8'h00);
      wr(18'h0_0034, 8'h01);
      `CHK(ppow, 1'b0);
      rd_chk(18'h0_0034, 8'h00);
      wr(18'h0_0034, 8'h02);
      rd_chk(18'h0_0034, 8'h02);
      wr(18'h0_4000, 8'ha5);
      rd_chk(18'h0_4000, 8'h00);
      wr(18'h0_0034, 8'h00);
      burn(18'h0_4000, 8'ha5);
      rd_chk(18'h0_4000, 8'ha5);
      burn(18'h0_7bfc, 8'h3c);
      rd_chk(18'h0_7bfc, 8'h3c);
      burn(18'h0_3ffc, 8'h36);
      rd_chk(18'h0_3ffc, 8'h00);
      do_reset(2'b10);
      `CHK(boot, 1'b0);
      do_reset(2'b11);
      `CHK(boot, 1'b1);
      `CHK(jumps, 1);
      `CHK(pbb_rel, 1'b1);
      `CHK(vec, 1'b0);
      burn(18'h0_3ffc, 8'h36);
      rd_chk(18'h0_3ffc, 8'h36);
      do_reset(2'b11);
      `CHK({slow, sec, dsel, osc}, 6'h36);
      `CHK(boot, 1'b1);
      repeat (18) @(posedge clk_i);
      `CHK(pdone, 1'b0);
      repeat (20) @(posedge clk_i);
      `CHK(pdone, 1'b1);
      ticks = 0;
      repeat (64) @(posedge clk_i);
      `CHK(ticks, 4);
      rd_chk(18'h0_4000, 8'h00);
      burn(18'h0_3ffc, 8'h01);
      do_reset(2'b11);
      `CHK(osc, 1'b1);
      `CHK(boot, 1'b0);
      `CHK(vec, 1'b1);
      rd_chk(18'h0_4000, 8'ha5);
      print_verdict();
   end
endmodule : eop_ctrl_tb

// ### bench/eop_pin_source.sv
// mode pin source: programming supply on the test voltage pin plus the port b bit 1 strap
// assumes the bench asks for pin levels and the block synchronises them itself
`timescale 1ns/10ps
module eop_pin_source (
   // clock
   input wire logic clk_i,
   // requested levels: bit 1 test voltage, bit 0 strap high
   input wire logic [1:0] req_i,
   // pins
   output logic test_voltage_level_o,
   output logic port_b_bit1_pin_o
);
   // levels move only just after an edge, like a real supply switch
   initial begin
      test_voltage_level_o = 1'b0;
      port_b_bit1_pin_o = 1'b0;
   end
   // supply present only when asked; software also programs with it absent
   always @(posedge clk_i) begin
      test_voltage_level_o <= req_i[1];
      port_b_bit1_pin_o <= req_i[0];
   end
endmodule : eop_pin_source

// ### hw/eop_ctrl.sv
// eprom programming control, mode entry and option latches
// assumes a classic wishbone master and synchronous reset held
// for at least three clock edges
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
// Behaviour
// - user mode at reset release unless both mode pins ask for bootstrap
// - bootstrap needs test voltage level and port b bit 1 high at release
// - bootstrap refused when the rc oscillator option is selected
// - port b bit 1 freed for other use once bootstrap entered
// - bootstrap entry jumps the cpu to the built-in bootstrap program
// - user eprom spans 3840 bytes from 1000 to 1eff
// - in user mode all vectors come from the eprom
// - latch set: eprom writes capture address and data, reads blocked
// - latch clear: eprom reads work normally
// - program bit powers the array and is zero without latch
// - one control write clears program and latch together
// - option byte erases to zero and is fixed in user mode
// - option byte copied to working latches at reset release
// - slow start option runs cpu at oscillator over 16
// - security option blocks eprom readout in bootstrap mode
// - power-on delay is 256 times two to the select code
// - oscillator bit: one selects rc, zero selects crystal
module eop_ctrl #(
   parameter int PROG_CYCLES = eop_pkg::PROG_CYCLES,
   parameter int POR_BASE = eop_pkg::POR_BASE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [eop_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire logic test_voltage_level_i,
   input wire logic port_b_bit1_pin_i,
   input wire logic array_erase_i,
   // mode status
   output logic boot_mode_o,
   output logic boot_jump_o,
   output logic port_b_bit1_released_o,
   output logic vectors_from_eprom_o,
   // programming power
   output logic prog_power_o,
   // option outputs
   output logic slow_mode_o,
   output logic security_lock_o,
   output logic osc_type_select_o,
   output logic [2:0] por_delay_sel_o,
   output logic por_done_o,
   output logic cpu_tick_o
);
   localparam int IW = eop_pkg::MEM_IDX_W;
   localparam int PCW = $clog2(PROG_CYCLES + 1);

   typedef struct packed {
      logic rst_q;
      logic tvl_m;
      logic tvl_q;
      logic pbb_m;
      logic pbb_q;
      logic boot;
      logic jump;
      logic pbb_rel;
      logic vec_eprom;
      logic [7:0] opt;
      logic latch;
      logic program_command;
      logic [IW-1:0] lat_idx;
      logic [7:0] lat_data;
      logic lat_valid;
      logic [PCW-1:0] prog_cnt;
      logic burned;
      logic burn;
      logic ack;
      logic [7:0] rdat;
   } eop_ctrl_t;

   eop_ctrl_t s_r;
   eop_ctrl_t s_nxt;

   // bus decode
   logic [15:0] idx;
   logic [15:0] mem_off;
   logic req;
   logic wr;
   logic rd;
   logic is_ctrl;
   logic is_opt;
   logic in_user;
   logic in_mem;
   logic release_now;
   logic want_boot;
   logic mem_wr_ok;
   logic [7:0] ctrl_val;

   eop_mem_if #(.IW(IW)) mem_b ();

   // word index and its offset into the cell array
   assign idx = wb_adr_i[eop_pkg::WB_ADR_W-1:eop_pkg::IDX_LSB];
   assign mem_off = idx - eop_pkg::OPT_IDX;
   assign req = wb_cyc_i && wb_stb_i && !s_r.ack;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign rd = req && !wb_we_i;
   assign is_ctrl = (idx == eop_pkg::CTRL_IDX);
   assign is_opt = (idx == eop_pkg::OPT_IDX);
   // user eprom window
   assign in_user = (idx >= eop_pkg::EPROM_FIRST) && (idx <= eop_pkg::EPROM_LAST);
   assign in_mem = is_opt || in_user;

   // release is the first cycle with reset low
   assign release_now = s_r.rst_q && !rst_i;
   assign want_boot = s_r.tvl_q && s_r.pbb_q;

   // option byte only programmable from bootstrap mode
   assign mem_wr_ok = in_user || (is_opt && s_r.boot);

   // control register read image
   always_comb begin
      ctrl_val = eop_pkg::CTRL_RST;
      ctrl_val[eop_pkg::LATCH_BIT] = s_r.latch;
      ctrl_val[eop_pkg::PROG_BIT] = s_r.program_command;
   end

   // cell array port
   assign mem_b.rd_idx = mem_off[IW-1:0];
   assign mem_b.burn = s_r.burn;
   assign mem_b.burn_idx = s_r.lat_idx;
   assign mem_b.burn_data = s_r.lat_data;

   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.rst_q = 1'b0;
      // pin synchronisers
      s_nxt.tvl_m = test_voltage_level_i;
      s_nxt.tvl_q = s_r.tvl_m;
      s_nxt.pbb_m = port_b_bit1_pin_i;
      s_nxt.pbb_q = s_r.pbb_m;
      s_nxt.jump = 1'b0;
      s_nxt.burn = 1'b0;

      // mode entry and option capture at reset release
      if (release_now) begin
         s_nxt.opt = mem_b.opt_byte;
         // crystal only for bootstrap
         s_nxt.boot = want_boot && !mem_b.opt_byte[eop_pkg::OSC_BIT];
         s_nxt.jump = s_nxt.boot;
         s_nxt.pbb_rel = s_nxt.boot;
         s_nxt.vec_eprom = !s_nxt.boot;
      end

      // control register write
      if (wr && is_ctrl) begin
         s_nxt.latch = wb_dat_i[eop_pkg::LATCH_BIT];
         // program forced low without latch
         s_nxt.program_command = wb_dat_i[eop_pkg::PROG_BIT] && wb_dat_i[eop_pkg::LATCH_BIT];
      end

      // latched write into the array range
      if (wr && in_mem && s_r.latch && mem_wr_ok) begin
         s_nxt.lat_idx = mem_off[IW-1:0];
         s_nxt.lat_data = wb_dat_i[7:0];
         s_nxt.lat_valid = 1'b1;
         s_nxt.burned = 1'b0;
      end
      if (!s_r.latch) begin
         s_nxt.lat_valid = 1'b0;
      end

      // burn once after the program bit held for the pulse time
      if (s_r.program_command && s_r.lat_valid && !s_r.burned) begin
         if (s_r.prog_cnt == (PCW)'(PROG_CYCLES - 1)) begin
            s_nxt.burn = 1'b1;
            s_nxt.burned = 1'b1;
            s_nxt.prog_cnt = '0;
         end else begin
            s_nxt.prog_cnt = s_r.prog_cnt + 1'b1;
         end
      end else if (!s_r.program_command) begin
         s_nxt.prog_cnt = '0;
         s_nxt.burned = 1'b0;
      end

      // bus answer one cycle after the request
      s_nxt.ack = req;
      s_nxt.rdat = 8'h00;
      if (rd && is_ctrl) begin
         s_nxt.rdat = ctrl_val;
      end else if (rd && in_mem) begin
         if (s_r.latch) begin
            s_nxt.rdat = 8'h00;
         end else if (s_r.boot && s_r.opt[eop_pkg::LOCK_BIT]) begin
            s_nxt.rdat = 8'h00;
         end else begin
            s_nxt.rdat = mem_b.rd_data;
         end
      end

      // synchronous reset keeps the pin synchronisers running
      if (rst_i) begin
         s_nxt = '0;
         s_nxt.rst_q = 1'b1;
         s_nxt.vec_eprom = 1'b1;
         s_nxt.tvl_m = test_voltage_level_i;
         s_nxt.tvl_q = s_r.tvl_m;
         s_nxt.pbb_m = port_b_bit1_pin_i;
         s_nxt.pbb_q = s_r.pbb_m;
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      s_r <= s_nxt;
   end

   // cell array
   eop_eprom_array #(
      .DEPTH(eop_pkg::MEM_DEPTH)
   ) u_array (
      .clk_i(clk_i),
      .erase_i(array_erase_i),
      .m(mem_b)
   );

   // power-on delay and slow mode enable
   eop_por_timer #(
      .POR_BASE(POR_BASE),
      .SLOW_DIV(eop_pkg::SLOW_DIV)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .delay_sel_i(s_r.opt[eop_pkg::DSEL_HI:eop_pkg::DSEL_LO]),
      .slow_i(s_r.opt[eop_pkg::SLOW_BIT]),
      .por_done_o(por_done_o),
      .cpu_tick_o(cpu_tick_o)
   );

   // outputs from the state register
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = {24'h00_0000, s_r.rdat};
   assign boot_mode_o = s_r.boot;
   assign boot_jump_o = s_r.jump;
   assign port_b_bit1_released_o = s_r.pbb_rel;
   assign vectors_from_eprom_o = s_r.vec_eprom;
   assign prog_power_o = s_r.program_command;
   assign slow_mode_o = s_r.opt[eop_pkg::SLOW_BIT];
   assign security_lock_o = s_r.opt[eop_pkg::LOCK_BIT];
   assign osc_type_select_o = s_r.opt[eop_pkg::OSC_BIT];
   assign por_delay_sel_o = s_r.opt[eop_pkg::DSEL_HI:eop_pkg::DSEL_LO];

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   user_entry_a: assert property (
      release_now && !want_boot |=> !boot_mode_o && vectors_from_eprom_o)
      else $error("user mode not entered");
   boot_entry_a: assert property (
      release_now && want_boot && !mem_b.opt_byte[eop_pkg::OSC_BIT]
      |=> boot_mode_o && port_b_bit1_released_o)
      else $error("bootstrap not entered");
   rc_no_boot_a: assert property (
      release_now && mem_b.opt_byte[eop_pkg::OSC_BIT] |=> !boot_mode_o)
      else $error("bootstrap entered with rc oscillator");
   boot_jump_a: assert property (
      boot_jump_o |=> !boot_jump_o && boot_mode_o)
      else $error("jump pulse malformed");
   opt_capture_a: assert property (
      release_now |=> s_r.opt == $past(mem_b.opt_byte))
      else $error("option byte not captured");
   opt_steady_a: assert property (
      !release_now |=> $stable(s_r.opt))
      else $error("option latches moved");
   pgm_latch_a: assert property (
      prog_power_o |-> s_r.latch)
      else $error("program power without latch");
   clear_both_a: assert property (
      wr && is_ctrl && !wb_dat_i[eop_pkg::LATCH_BIT]
      |=> !prog_power_o && !s_r.latch)
      else $error("single write did not clear both");
   read_block_a: assert property (
      rd && in_mem && s_r.latch |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("eprom read while latched");
   secure_read_a: assert property (
      rd && in_user && s_r.boot && s_r.opt[eop_pkg::LOCK_BIT]
      |=> wb_dat_o == 32'h0000_0000)
      else $error("secured eprom read out");
   opt_lock_a: assert property (
      wr && is_opt && !s_r.boot && !s_r.lat_valid |=> !s_r.lat_valid)
      else $error("option byte latched in user mode");
   burn_gate_a: assert property (
      s_r.burn |-> $past(prog_power_o) && $past(s_r.lat_valid))
      else $error("burn without program power");
   ack_once_a: assert property (
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle pulse");

   // main scenarios
   boot_seen_c: cover property (release_now ##1 boot_mode_o);
   burn_seen_c: cover property (s_r.burn);
   user_read_c: cover property (rd && in_user && !s_r.latch ##1 wb_ack_o);
   secure_c: cover property (rd && in_user && security_lock_o && boot_mode_o);
endmodule : eop_ctrl

// ### hw/eop_eprom_array.sv
// eprom cell array: option byte at entry 0, user bytes above
// assumes erase_i models the ultraviolet erase; reset leaves cells alone
`timescale 1ns/10ps
module eop_eprom_array #(
   parameter int DEPTH = 3841
) (
   // clock and erase
   input wire logic clk_i,
   input wire logic erase_i,
   // controller side
   eop_mem_if.array m
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] cells;
   } eop_arr_t;

   eop_arr_t s_r;
   eop_arr_t s_nxt;

   // burn only ever sets bits, erase returns all to zero
   always_comb begin
      s_nxt = s_r;
      if (erase_i) begin
         s_nxt.cells = {DEPTH{eop_pkg::ERASED}};
      end else if (m.burn && (m.burn_idx < DEPTH)) begin
         s_nxt.cells[m.burn_idx] = s_r.cells[m.burn_idx] | m.burn_data;
      end
   end

   always_ff @(posedge clk_i) begin
      s_r <= s_nxt;
   end

   // read port
   assign m.rd_data = (m.rd_idx < DEPTH) ? s_r.cells[m.rd_idx] : eop_pkg::ERASED;
   assign m.opt_byte = s_r.cells[0];
endmodule : eop_eprom_array

// ### hw/eop_por_timer.sv
// power-on delay counter and slow-mode cpu enable divider
// assumes one clk_i cycle per instruction cycle
`timescale 1ns/10ps
module eop_por_timer #(
   parameter int POR_BASE = 256,
   parameter int SLOW_DIV = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // option latches
   input wire logic [2:0] delay_sel_i,
   input wire logic slow_i,
   // status
   output logic por_done_o,
   output logic cpu_tick_o
);
   localparam int LW = $clog2(POR_BASE) + 8;
   localparam int DW = $clog2(SLOW_DIV);
   typedef struct packed {
      logic [LW-1:0] cnt;
      logic done;
      logic [DW-1:0] div;
      logic tick;
   } eop_tmr_t;

   eop_tmr_t s_r;
   eop_tmr_t s_nxt;
   logic [LW-1:0] lim;

   // delay is base times two to the select code
   assign lim = (LW)'(POR_BASE) << delay_sel_i;

   always_comb begin
      s_nxt = s_r;
      if (!s_r.done) begin
         if (s_r.cnt == lim - 1'b1) begin
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end
      // slow mode: one cpu enable each sixteen cycles
      if (slow_i) begin
         s_nxt.tick = (s_r.div == (DW)'(SLOW_DIV - 1));
         s_nxt.div = s_nxt.tick ? '0 : s_r.div + 1'b1;
      end else begin
         s_nxt.div = '0;
         s_nxt.tick = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign por_done_o = s_r.done;
   assign cpu_tick_o = s_r.tick;

   por_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(s_r.done) |-> $past(s_r.cnt) == lim - 1'b1)
      else $error("power-on delay ended at wrong count");
   slow_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      slow_i && s_r.tick ##1 slow_i |-> !s_r.tick)
      else $error("slow mode enable not spaced");
endmodule : eop_por_timer

// ### shared/eop_mem_if.sv
// link between the controller and the eprom cell array
// assumes both ends on the same clock
`timescale 1ns/10ps
interface eop_mem_if #(parameter int IW = 12);
   logic [IW-1:0] rd_idx;
   logic [7:0] rd_data;
   logic [7:0] opt_byte;
   logic burn;
   logic [IW-1:0] burn_idx;
   logic [7:0] burn_data;
   modport ctrl (
      output rd_idx, burn, burn_idx, burn_data,
      input rd_data, opt_byte
   );
   modport array (
      input rd_idx, burn, burn_idx, burn_data,
      output rd_data, opt_byte
   );
endinterface : eop_mem_if

// ### shared/eop_pkg.sv
// constants for the eprom programming and option control block
// assumes a 20 MHz cpu cycle clock and a word-indexed wishbone map
package eop_pkg;
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned PROG_TIME_MS = 1;
   localparam int unsigned PROG_CYCLES =
      (PROG_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POR_BASE_CYCLES = 256;
   localparam int unsigned SLOW_DIV = 16;
   // register indexes, byte address is four times the index
   localparam logic [15:0] CTRL_IDX = 16'h000d;
   localparam logic [15:0] OPT_IDX = 16'h0fff;
   localparam logic [15:0] EPROM_FIRST = 16'h1000;
   localparam logic [15:0] EPROM_LAST = 16'h1eff;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned WB_ADR_W = 18;
   // cell array: option byte at entry 0, user eprom after it
   localparam int unsigned EPROM_BYTES = 3840;
   localparam int unsigned MEM_DEPTH = EPROM_BYTES + 1;
   localparam int unsigned MEM_IDX_W = 12;
   localparam logic [7:0] ERASED = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // control register fields
   localparam int unsigned LATCH_BIT = 1;
   localparam int unsigned PROG_BIT = 0;
   // option byte fields
   localparam int unsigned SLOW_BIT = 5;
   localparam int unsigned LOCK_BIT = 4;
   localparam int unsigned DSEL_HI = 3;
   localparam int unsigned DSEL_LO = 1;
   localparam int unsigned OSC_BIT = 0;
endpackage : eop_pkg
